// File: logic/wcp_map.vh
// constants for the watchdog, wake counters, clock switch and power modes
// ------------------------------------------------------------
// ------------------------------------------------------------
`ifndef WCP_MAP_VH
`define WCP_MAP_VH
`define WCP_FAST_OSC_KHZ     48000
`define WCP_SLOW_OSC_KHZ     32
`define WCP_CORE_CLK_KHZ     100000
`define WCP_WDT_W            16
`define WCP_WDT_RESET        16'h0200
`define WCP_WAKE_W           16
`define WCP_WAKE_RESET       16'h0400
`define WCP_NUM_PORTS        2
`define WCP_SEQ_CYCLES       8'h10
`define WCP_RST_PULSE        8'h08
`define WCP_MODE_SEQ         2'h0
`define WCP_MODE_ACTIVE      2'h1
`define WCP_MODE_SLEEP       2'h2
`define WCP_SEL_FAST         1'b0
`define WCP_SEL_SLOW         1'b1
`endif

// File: logic/wcp_clk_switch.v
// glitch-free two-source clock selector
`timescale 1ns/1ns
module wcp_clk_switch (
  input  wire fast_clk_i,
  input  wire slow_clk_i,
  input  wire resetn_i,
  input  wire sel_slow_i,
  output wire clk_o,
  output wire fast_on_o,
  output wire slow_on_o
);
  reg fast_s1_r;
  reg fast_s2_r;
  reg slow_s1_r;
  reg slow_s2_r;

  // ------------------------------------------------------------
  // cross-coupled enables
  // ------------------------------------------------------------
  // each side waits until the other is gated off, then enables on its own
  // falling edge so no runt pulse reaches the output
  always @(negedge fast_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      fast_s1_r <= 1'b1;
      fast_s2_r <= 1'b1;
    end else begin
      fast_s1_r <= ~sel_slow_i & ~slow_s2_r;
      fast_s2_r <= fast_s1_r;
    end
  end

  always @(negedge slow_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      slow_s1_r <= 1'b0;
      slow_s2_r <= 1'b0;
    end else begin
      slow_s1_r <= sel_slow_i & ~fast_s2_r;
      slow_s2_r <= slow_s1_r;
    end
  end

  // fast oscillator is the source coming out of reset
  assign clk_o     = (fast_clk_i & fast_s2_r) | (slow_clk_i & slow_s2_r);
  assign fast_on_o = fast_s2_r;
  assign slow_on_o = slow_s2_r;
endmodule

// File: logic/wcp_top.v
// watchdog, port wake counters, clock selection and power-mode sequencer
`timescale 1ns/1ns
`include "wcp_map.vh"
module wcp_top (
  input  wire                                   core_clk_i,
  input  wire                                   resetn_i,
  input  wire                                   clk_en_i,
  input  wire                                   fast_osc_clk_i,
  input  wire                                   slow_osc_clk_i,
  input  wire                                   external_reset_pin_n_i,
  input  wire                                   power_valid_i,
  input  wire                                   int_reset_req_i,
  input  wire                                   wdt_service_i,
  input  wire                                   wdt_enable_i,
  input  wire                                   sleep_req_i,
  input  wire                                   wake_req_i,
  input  wire [`WCP_NUM_PORTS-1:0]              wake_en_i,
  input  wire [`WCP_NUM_PORTS*`WCP_WAKE_W-1:0]  wake_period_i,
  output wire                                   sys_clk_o,
  output wire                                   serial_comm_block_clk_o,
  output wire [`WCP_NUM_PORTS-1:0]              pd_clk_o,
  output reg                                    chip_reset_o,
  output reg  [1:0]                             power_mode_o,
  output reg                                    main_reg_en_o,
  output reg                                    cpu_run_o,
  output reg  [`WCP_NUM_PORTS-1:0]              port_wake_o,
  output reg  [`WCP_WDT_W-1:0]                  wdt_count_o
);
  // ------------------------------------------------------------
  // pin and slow-clock synchronisers
  // ------------------------------------------------------------
  // the slow oscillator is sampled as a level; a rising edge counts once
  // second and third stages agree on high after having agreed on low
  reg [2:0] slow_sync_r;
  reg [2:0] external_reset_pin_sync_r;
  reg       slow_lvl_r;
  reg       external_reset_pin_lvl_r;
  wire      slow_tick;

  always @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      slow_sync_r <= 3'h0;
      external_reset_pin_sync_r <= 3'h0;
      slow_lvl_r  <= 1'b0;
      external_reset_pin_lvl_r  <= 1'b0;
    end else if (clk_en_i) begin
      slow_sync_r <= {slow_sync_r[1:0], slow_osc_clk_i};
      external_reset_pin_sync_r <= {external_reset_pin_sync_r[1:0], external_reset_pin_n_i};
      if (slow_sync_r[1] == slow_sync_r[2])
        slow_lvl_r <= slow_sync_r[2];
      if (external_reset_pin_sync_r[1] == external_reset_pin_sync_r[2])
        external_reset_pin_lvl_r <= external_reset_pin_sync_r[2];
    end
  end

  // one tick per slow-oscillator period; rate is only nominal, so nothing
  // derived from it claims precise time
  assign slow_tick = (slow_sync_r[1] == slow_sync_r[2]) & slow_sync_r[2] & ~slow_lvl_r;

  // ------------------------------------------------------------
  // power-mode sequencer
  // ------------------------------------------------------------
  localparam ST_OFF    = 2'h0;
  localparam ST_SEQ    = 2'h1;
  localparam ST_ACTIVE = 2'h2;
  localparam ST_SLEEP  = 2'h3;

  reg [1:0] state_r;
  reg [1:0] state_nxt;
  reg [7:0] seq_cnt_r;
  reg [7:0] rst_cnt_r;
  wire      wdt_expire;
  wire      sys_ok;

  assign sys_ok = power_valid_i & external_reset_pin_lvl_r;

  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_OFF:    if (sys_ok) state_nxt = ST_SEQ;
      ST_SEQ: begin
        // held here while an internal source is active or wakeup runs
        if (!sys_ok)
          state_nxt = ST_OFF;
        else if (!int_reset_req_i && rst_cnt_r == 8'h00 && seq_cnt_r == `WCP_SEQ_CYCLES)
          state_nxt = ST_ACTIVE;
      end
      ST_ACTIVE: begin
        if (!sys_ok)
          state_nxt = ST_OFF;
        else if (int_reset_req_i || wdt_expire)
          state_nxt = ST_SEQ;
        else if (sleep_req_i)
          state_nxt = ST_SLEEP;
      end
      ST_SLEEP: begin
        if (!sys_ok)
          state_nxt = ST_OFF;
        else if (int_reset_req_i || wdt_expire)
          state_nxt = ST_SEQ;
        else if (wake_req_i || (|port_wake_o))
          state_nxt = ST_SEQ;
      end
      default:   state_nxt = ST_OFF;
    endcase
  end

  always @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_r   <= ST_OFF;
      seq_cnt_r <= 8'h00;
      rst_cnt_r <= 8'h00;
    end else if (clk_en_i) begin
      state_r <= state_nxt;
      if (state_nxt != ST_SEQ)
        seq_cnt_r <= 8'h00;
      else if (seq_cnt_r != `WCP_SEQ_CYCLES)
        seq_cnt_r <= seq_cnt_r + 8'h01;
      // watchdog reset pulse length
      if (wdt_expire)
        rst_cnt_r <= `WCP_RST_PULSE;
      else if (rst_cnt_r != 8'h00)
        rst_cnt_r <= rst_cnt_r - 8'h01;
    end
  end

  // registered mode outputs; they follow state_nxt so the pins change on
  // the same edge as the state itself, with no extra cycle of lag
  always @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      power_mode_o  <= `WCP_MODE_SEQ;
      main_reg_en_o <= 1'b1;
      cpu_run_o     <= 1'b0;
      chip_reset_o  <= 1'b1;
    end else if (clk_en_i) begin
      chip_reset_o  <= (state_nxt == ST_OFF) | (state_nxt == ST_SEQ);
      cpu_run_o     <= (state_nxt == ST_ACTIVE);
      main_reg_en_o <= (state_nxt != ST_SLEEP);
      case (state_nxt)
        ST_ACTIVE: power_mode_o <= `WCP_MODE_ACTIVE;
        ST_SLEEP:  power_mode_o <= `WCP_MODE_SLEEP;
        default:   power_mode_o <= `WCP_MODE_SEQ;
      endcase
    end
  end

  // ------------------------------------------------------------
  // clock source selection
  // ------------------------------------------------------------
  // deep sleep keeps only the slow oscillator, so the switch follows it
  wire sel_slow;
  assign sel_slow = (state_r == ST_SLEEP) ? `WCP_SEL_SLOW : `WCP_SEL_FAST;

  wcp_clk_switch u_clk_switch (
    .fast_clk_i (fast_osc_clk_i),
    .slow_clk_i (slow_osc_clk_i),
    .resetn_i   (resetn_i),
    .sel_slow_i (sel_slow),
    .clk_o      (sys_clk_o),
    .fast_on_o  (),
    .slow_on_o  ()
  );

  // every consumer gets the switched clock
  assign serial_comm_block_clk_o = sys_clk_o;
  assign pd_clk_o                = {`WCP_NUM_PORTS{sys_clk_o}};

  // ------------------------------------------------------------
  // supervision timer
  // ------------------------------------------------------------
  // true in the modes where the timer may run; sequencing and off hold it
  // at the reload value so every boot starts with the full timeout
  function timer_live;
    input [1:0] st;
    begin
      timer_live = (st == ST_ACTIVE) | (st == ST_SLEEP);
    end
  endfunction

  // counts slow ticks in active and deep sleep only, not in off or sequencing; a service in the
  // same cycle as the expiring tick wins, so live firmware is never reset
  assign wdt_expire = wdt_enable_i & timer_live(state_r) &
                      slow_tick & (wdt_count_o == {`WCP_WDT_W{1'b0}}) & ~wdt_service_i;

  always @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wdt_count_o <= `WCP_WDT_RESET;
    end else if (clk_en_i) begin
      if (wdt_service_i || !wdt_enable_i || !timer_live(state_r))
        wdt_count_o <= `WCP_WDT_RESET;
      else if (slow_tick && wdt_count_o != {`WCP_WDT_W{1'b0}})
        wdt_count_o <= wdt_count_o - {{(`WCP_WDT_W-1){1'b0}}, 1'b1};
    end
  end

  // ------------------------------------------------------------
  // per-port periodic wake counters
  // ------------------------------------------------------------
  // while a port is disabled its counter tracks the period input, so the
  // first wake after enabling comes a full period plus one tick later
  genvar p;
  generate
    for (p = 0; p < `WCP_NUM_PORTS; p = p + 1) begin : g_port
      reg [`WCP_WAKE_W-1:0] wake_cnt_r;
      always @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
          wake_cnt_r     <= `WCP_WAKE_RESET;
          port_wake_o[p] <= 1'b0;
        end else if (clk_en_i) begin
          port_wake_o[p] <= 1'b0;
          if (!wake_en_i[p]) begin
            wake_cnt_r <= wake_period_i[p*`WCP_WAKE_W +: `WCP_WAKE_W];
          end else if (slow_tick) begin
            if (wake_cnt_r == {`WCP_WAKE_W{1'b0}}) begin
              wake_cnt_r     <= wake_period_i[p*`WCP_WAKE_W +: `WCP_WAKE_W];
              port_wake_o[p] <= 1'b1;
            end else begin
              wake_cnt_r <= wake_cnt_r - {{(`WCP_WAKE_W-1){1'b0}}, 1'b1};
            end
          end
        end
      end
    end
  endgenerate
endmodule

// File: testbench/wcp_top_props.sv
// concurrent checks on the power modes, watchdog count and wake pulses
`timescale 1ns/1ns
`include "wcp_map.vh"
module wcp_top_props (
  input wire        core_clk_i,
  input wire        resetn_i,
  input wire        clk_en_i,
  input wire        wdt_service_i,
  input wire        sleep_req_i,
  input wire        wake_req_i,
  input wire        sys_clk_o,
  input wire        serial_comm_block_clk_o,
  input wire [1:0]  pd_clk_o,
  input wire        chip_reset_o,
  input wire [1:0]  power_mode_o,
  input wire        main_reg_en_o,
  input wire        cpu_run_o,
  input wire [1:0]  port_wake_o,
  input wire [15:0] wdt_count_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!resetn_i);
  // mode moves land one or two edges after the request
  sequence to_sleep_s; ##[1:2] power_mode_o == 2'h2; endsequence
  sequence to_seq_s; ##[1:2] power_mode_o == 2'h0; endsequence
  sleep_regs_off_a: assert property (power_mode_o == 2'h2 |-> !main_reg_en_o && !cpu_run_o)
    else $error("sleep mode with regulator or cpu on");
  active_cpu_a: assert property (power_mode_o == 2'h1 |-> cpu_run_o && !chip_reset_o)
    else $error("active mode without cpu running");
  seq_reset_a: assert property (power_mode_o == 2'h0 |-> chip_reset_o)
    else $error("sequencing mode without chip reset");
  clk_fanout_a: assert property (serial_comm_block_clk_o == sys_clk_o && pd_clk_o == {2{sys_clk_o}})
    else $error("consumer clock differs from system clock");
  sleep_entry_a: assert property (clk_en_i && power_mode_o == 2'h1 && sleep_req_i && wdt_count_o > 16'h1 |-> to_sleep_s)
    else $error("sleep request not taken");
  sleep_wake_a: assert property (clk_en_i && power_mode_o == 2'h2 && wake_req_i |-> to_seq_s)
    else $error("wake request not taken");
  timer_reload_a: assert property (clk_en_i && wdt_service_i |=> wdt_count_o == `WCP_WDT_RESET)
    else $error("service did not reload timer");
  timer_step_a: assert property (wdt_count_o != $past(wdt_count_o) |->
    wdt_count_o == $past(wdt_count_o) - 16'h1 || wdt_count_o == `WCP_WDT_RESET)
    else $error("timer moved by other than one step");
  wake_pulse_a: assert property (port_wake_o != 2'h0 |=> (port_wake_o & $past(port_wake_o)) == 2'h0)
    else $error("wake pulse longer than one cycle");
endmodule
bind wcp_top wcp_top_props wcp_top_props_i (.core_clk_i, .resetn_i, .clk_en_i, .wdt_service_i, .sleep_req_i,
  .wake_req_i, .sys_clk_o, .serial_comm_block_clk_o, .pd_clk_o, .chip_reset_o, .power_mode_o, .main_reg_en_o,
  .cpu_run_o, .port_wake_o, .wdt_count_o);

// File: testbench/wcp_top_test.sv
// self-checking bench for the watchdog, wake counters and power modes
`timescale 1ns/1ns
`include "wcp_map.vh"
module wcp_top_test;
  reg         clk, rstn, clk_en, fast, slow, svc, wen, slp, wak;
  reg         pwr, xrn, irq;
  reg  [1:0]  wake_en;
  reg  [31:0] period;
  reg  [15:0] c0;
  wire        sys_clk, ser_clk, crst, mreg, cpu;
  wire [1:0]  pd_clk, mode, wake;
  wire [15:0] cnt;
  integer     bad_count, n_tests, t, e;
  wcp_top wcp_top_i (.core_clk_i(clk), .resetn_i(rstn), .clk_en_i(clk_en), .fast_osc_clk_i(fast),
    .slow_osc_clk_i(slow), .external_reset_pin_n_i(xrn), .power_valid_i(pwr), .int_reset_req_i(irq),
    .wdt_service_i(svc), .wdt_enable_i(wen), .sleep_req_i(slp), .wake_req_i(wak), .wake_en_i(wake_en),
    .wake_period_i(period), .sys_clk_o(sys_clk), .serial_comm_block_clk_o(ser_clk), .pd_clk_o(pd_clk),
    .chip_reset_o(crst), .power_mode_o(mode), .main_reg_en_o(mreg), .cpu_run_o(cpu), .port_wake_o(wake),
    .wdt_count_o(cnt));
  // ------------------------------------------------------------
  // clocks: slow one offset so it never toggles on a core edge
  // ------------------------------------------------------------
  initial begin clk = 0; forever #5 clk = ~clk; end
  initial begin fast = 0; forever begin #10 fast = 1; #11 fast = 0; end end
  initial begin slow = 0; #2; forever #30 slow = ~slow; end
  task chk(input [63:0] what, input [15:0] exp, input [15:0] got);
    begin
      n_tests = n_tests + 1;
      if (got !== exp) begin
        bad_count = bad_count + 1;
        $display("BAD %0s exp %h got %h", what, exp, got);
      end
    end
  endtask
  task complete_run;
    begin
      $display("checks %0d bad %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  // bounded wait, t holds the cycles spent; running out counts as a mismatch
  task wait_mode(input [1:0] m);
    begin
      t = 0;
      while (mode !== m && t < 400) begin @(negedge clk); t = t + 1; end
      if (mode !== m) begin
        bad_count = bad_count + 1;
        $display("BAD wait_mode exp %h got %h", m, mode);
      end
    end
  endtask
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task t_boot;
    begin
      rstn = 1;
      repeat (5) @(negedge clk);
      chk("rst", 1, crst);
      wait_mode(2'h1);
      chk("seqlen", 1, t >= 16);
      chk("cpu", 3, {cpu, mreg});
      // sampled just after each fast edge so the gate has settled
      e = 0;
      repeat (8) begin
        @(posedge fast);
        #1;
        if (sys_clk !== 1'b1) e = e + 1;
        @(negedge fast);
        #1;
        if (sys_clk !== 1'b0) e = e + 1;
      end
      @(negedge clk);
      chk("fastclk", 0, e);
    end
  endtask
  // one slow tick every 6 cycles, so 60 cycles is exactly 10 ticks
  task t_wdt;
    begin
      wen = 1;
      repeat (12) @(negedge clk);
      c0 = cnt;
      repeat (60) @(negedge clk);
      chk("dec", c0 - 16'd10, cnt);
      clk_en = 0;
      c0 = cnt;
      repeat (30) @(negedge clk);
      chk("freeze", c0, cnt);
      clk_en = 1;
      svc = 1;
      @(negedge clk);
      svc = 0;
      chk("svc", `WCP_WDT_RESET, cnt);
      repeat (60) @(negedge clk);
      chk("restart", `WCP_WDT_RESET - 16'd10, cnt);
    end
  endtask
  task t_wake;
    integer p;
    begin
      period = {16'h0005, 16'h0003};
      wake_en = 2'h3;
      for (p = 0; p < 2; p = p + 1) begin
        t = 0;
        while (wake[p] !== 1'b1 && t < 400) begin @(negedge clk); t = t + 1; end
        t = 0;
        @(negedge clk);
        while (wake[p] !== 1'b1 && t < 400) begin @(negedge clk); t = t + 1; end
        chk("wake", 24 + 12 * p, t + 1);
      end
      wake_en = 2'h0;
    end
  endtask
  task t_sleep;
    begin
      slp = 1;
      @(negedge clk);
      slp = 0;
      wait_mode(2'h2);
      chk("sleep", 0, {mreg, cpu});
      c0 = cnt;
      repeat (60) @(negedge clk);
      chk("slpcnt", c0 - 16'd10, cnt);
      repeat (200) @(negedge clk);
      e = 0;
      repeat (24) begin @(negedge clk); if (sys_clk !== slow) e = e + 1; end
      chk("sysclk", 0, e);
      chk("fanout", {3{sys_clk}}, {ser_clk, pd_clk});
      wak = 1;
      @(negedge clk);
      wak = 0;
      wait_mode(2'h0);
      chk("wakerst", 1, crst);
      wait_mode(2'h1);
      chk("back", 1, cpu);
      slp = 1;
      @(negedge clk);
      slp = 0;
      wait_mode(2'h2);
      // port 0 still holds its period, so its first pulse wakes the chip
      wake_en = 2'h1;
      wait_mode(2'h0);
      chk("portwake", 3'h4, {crst, mode});
      wake_en = 2'h0;
      wait_mode(2'h1);
    end
  endtask
  task t_resets;
    begin
      irq = 1;
      repeat (30) @(negedge clk);
      chk("intrst", 2, {crst, cpu});
      irq = 0;
      wait_mode(2'h1);
      chk("intrel", 1, t <= 2);
      xrn = 0;
      repeat (10) @(negedge clk);
      chk("external_reset_pin", 2, {crst, cpu});
      xrn = 1;
      wait_mode(2'h1);
      chk("xresrel", 1, t >= 16);
      pwr = 0;
      @(negedge clk);
      chk("pwr", 2, {crst, cpu});
      pwr = 1;
      wait_mode(2'h1);
      chk("pwrrel", 1, t >= 16);
    end
  endtask
  // slow clock ticks every 6 core cycles here, so an unserviced timer
  // expires one to six cycles after six times its reload value
  task t_expire;
    begin
      t = 0;
      while (crst !== 1'b1 && t < 4000) begin @(negedge clk); t = t + 1; end
      chk("expire", 1, t > 6 * `WCP_WDT_RESET && t <= 6 * `WCP_WDT_RESET + 6);
      chk("expmode", 2, {crst, cpu});
      wait_mode(2'h1);
      chk("exprel", 1, t >= 16);
    end
  endtask
  // about twice the expected run, most of it the watchdog expiry wait
  initial begin #80000; bad_count = bad_count + 1; complete_run; end
  initial begin
    bad_count = 0;
    n_tests = 0;
    {rstn, svc, wen, slp, wak} = 5'h00;
    {pwr, xrn, irq} = 3'h6;
    clk_en = 1;
    wake_en = 2'h0;
    period = 32'h0;
    repeat (8) @(negedge clk);
    t_boot;
    t_wdt;
    t_wake;
    t_sleep;
    t_resets;
    t_expire;
    complete_run;
  end
endmodule
